/* File: plt_pkg.sv */
// constants and types for the programmable-length up/down timer
// Overview of operation
// - Count steps up or down on every divided timer clock edge while enabled.
// - Clear bit zeroes count, divider state and latched direction.
// - Software count writes apply at once and never raise flags.
// - Length select gives 8, 10, 12 or 16 bits; max FF/3FF/FFF/FFFF.
// - Short lengths store written count right-aligned, upper bits zero.
// - Clock from one of four sources, then divided by 1, 2, 4 or 8.
// - Counting only while mode is nonzero and the source clock runs.
// - Up or up/down: zero period halts; nonzero restarts upward from zero.
// - Mode codes: 00 stop, 01 up, 10 continuous, 11 up/down.
// - Up mode counts zero to period then zero; period+1 counts.
// - Entering up mode above period restarts the count from zero.
// - Up mode: match flag at period, rollover flag on period to zero.
// - Up mode immediate period change: count to new period or roll.
// - Continuous mode wraps at length max, rollover flag on max to zero.
// - Continuous mode: channel 0 compare is a plain compare, no limit.
// - Up/down counts zero to period and back; full period twice period.
// - Up/down with period above length max acts as continuous mode.
// - Direction is latched across stop and restart; only clear, or a nonzero period load after a zero period in up or up/down mode, resets it.
// - Up/down: match on period-1 to period, rollover on 1 to 0.
// - Up/down, period changed counting down: continue to zero first.
// - Up/down, period changed counting up: up to it or turn down.
package plt_pkg;
    localparam int unsigned CW = 16;
    localparam int unsigned AW = 8;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_CCR0 = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    // control layout, clear bit sits just above the stored fields
    localparam int unsigned CTRL_W = 11;
    localparam int unsigned CLR_BIT = 11;
    localparam logic [10:0] CTRL_RST = 11'h000;
    // status bit positions
    localparam int unsigned ST_ROLL = 0;
    localparam int unsigned ST_MATCH = 1;
    localparam int unsigned ST_DOWN = 2;
    localparam logic [15:0] CNT_RST = 16'h0000;
    // mode codes
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_UP = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    localparam logic [1:0] MODE_UPDN = 2'h3;
    // length codes and their maxima
    localparam logic [1:0] LEN_8 = 2'h0;
    localparam logic [1:0] LEN_10 = 2'h1;
    localparam logic [1:0] LEN_12 = 2'h2;
    localparam logic [15:0] MAX_8 = 16'h00FF;
    localparam logic [15:0] MAX_10 = 16'h03FF;
    localparam logic [15:0] MAX_12 = 16'h0FFF;
    localparam logic [15:0] MAX_16 = 16'hFFFF;
    // clock source codes
    localparam logic [1:0] SRC_AUX = 2'h0;
    localparam logic [1:0] SRC_SUB = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    // period latch load events
    localparam logic [1:0] LLS_IMM = 2'h0;
    localparam logic [1:0] LLS_OLD = 2'h3;
    typedef struct packed {
        logic [1:0] lls;
        logic irq_en;
        logic [1:0] len;
        logic [1:0] div;
        logic [1:0] src;
        logic [1:0] mode;
    } plt_ctrl_s;
endpackage : plt_pkg

/* File: plt_timer.sv */
// programmable-length up/down timer main counter with apb registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module plt_timer
    import plt_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic arst_n, // async reset, low active
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [AW-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic aux_clock, // source 0 level
    input wire logic sub_main_clock, // source 1 level
    input wire logic external_timer_clock, // source 2 level
    input wire logic alternate_external_clock, // source 3 level
    output logic irq // rollover interrupt request
);

    // maximum count for a length code
    function automatic logic [CW-1:0] len_max(input logic [1:0] len);
        case (len)
            LEN_8: len_max = MAX_8;
            LEN_10: len_max = MAX_10;
            LEN_12: len_max = MAX_12;
            default: len_max = MAX_16;
        endcase
    endfunction : len_max

    plt_ctrl_s ctrl_q, ctrl_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] per_q, per_d;
    logic [CW-1:0] ccr_q, ccr_d;
    logic dir_q, dir_d;
    logic pend_q, pend_d;
    logic roll_q, roll_d;
    logic match_q, match_d;
    logic src_q;
    logic [2:0] div_q, div_d;
    logic irq_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [CW-1:0] nxt;
    logic ndir, s_roll, s_match;

    // apb decode; one wait state so every answer leaves a flop
    wire acc = psel & penable;
    wire done = acc & pready_q;
    wire wr = done & pwrite;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_cnt = paddr == OFS_COUNT;
    wire hit_ccr = paddr == OFS_CCR0;
    wire hit_per = paddr == OFS_PERIOD;
    wire hit_stat = paddr == OFS_STAT;
    wire mapped = hit_ctrl | hit_cnt | hit_ccr | hit_per | hit_stat;
    wire clr = wr & hit_ctrl & pwdata[CLR_BIT];
    wire cnt_wr = wr & hit_cnt;
    wire ccr_wr = wr & hit_ccr;
    wire stat_wr = wr & hit_stat;
    wire plt_ctrl_s wctrl = plt_ctrl_s'(pwdata[CTRL_W-1:0]);

    // clock source select and divider
    wire src_lvl = (ctrl_q.src == SRC_AUX) ? aux_clock :
        (ctrl_q.src == SRC_SUB) ? sub_main_clock :
        (ctrl_q.src == SRC_EXT) ? external_timer_clock :
        alternate_external_clock;
    wire src_rise = src_lvl & ~src_q;
    wire [2:0] div_top = 3'((4'h1 << ctrl_q.div) - 4'h1);
    wire tick = src_rise & (div_q == div_top);

    // count view at the chosen length
    wire [CW-1:0] maxv = len_max(ctrl_q.len);
    wire [CW-1:0] cur = cnt_q & maxv;
    wire [CW-1:0] inc = CW'(cur + 16'h0001);
    wire [CW-1:0] dec = CW'(cur - 16'h0001);
    wire run = ctrl_q.mode != MODE_STOP;
    wire per_zero = per_q == CNT_RST;
    wire ud_cont = per_q > maxv;
    wire step_ok = tick & run;

    // next count, direction and flag events for one timer step
    always_comb begin
        nxt = cur;
        ndir = dir_q;
        s_roll = 1'b0;
        s_match = 1'b0;
        case (ctrl_q.mode)
            MODE_UP: begin
                if (per_zero) begin
                    nxt = cur;
                end else if (cur >= per_q) begin
                    nxt = CNT_RST;
                    s_roll = cur == per_q;
                end else begin
                    nxt = inc;
                    s_match = inc == per_q;
                end
            end
            MODE_CONT: begin
                if (cur == maxv) begin
                    nxt = CNT_RST;
                    s_roll = 1'b1;
                end else begin
                    nxt = inc;
                end
                s_match = nxt == per_q;
            end
            MODE_UPDN: begin
                if (per_zero) begin
                    nxt = cur;
                end else if (ud_cont) begin
                    if (cur == maxv) begin
                        nxt = CNT_RST;
                        s_roll = 1'b1;
                    end else begin
                        nxt = inc;
                    end
                    s_match = nxt == per_q;
                end else if (!dir_q) begin
                    if (cur >= per_q) begin
                        // turn at the top, or early if the period shrank
                        nxt = dec;
                        ndir = dec != CNT_RST;
                        s_roll = dec == CNT_RST;
                    end else begin
                        nxt = inc;
                        s_match = inc == per_q;
                    end
                end else if (cur == CNT_RST) begin
                    nxt = inc;
                    ndir = 1'b0;
                end else begin
                    // keeps falling whatever the period now is
                    nxt = dec;
                    if (cur == 16'h0001) begin
                        s_roll = 1'b1;
                        ndir = 1'b0;
                    end
                end
            end
            default: begin
                nxt = cur;
            end
        endcase
    end

    // period latch loading from the channel 0 register
    wire load_now = ccr_wr & (ctrl_q.lls == LLS_IMM);
    wire load_hit = (ctrl_q.lls == LLS_OLD) ? (nxt == per_q) :
        (nxt == CNT_RST);
    wire load_evt = pend_q & step_ok & load_hit;
    wire [CW-1:0] new_per = load_now ? pwdata[CW-1:0] : ccr_q;
    wire per_load = load_now | load_evt;
    wire bounded = (ctrl_q.mode == MODE_UP) | (ctrl_q.mode == MODE_UPDN);
    wire restart = per_load & per_zero & bounded &
        (new_per != CNT_RST);
    wire enter_up = wr & hit_ctrl & (wctrl.mode == MODE_UP) &
        (ctrl_q.mode != MODE_UP) & (cur > per_q);
    // a direct load or clear in the same cycle overrides the step
    wire step_use = step_ok & ~clr & ~cnt_wr & ~restart &
        ~enter_up;

    // next values of the software visible state
    assign ctrl_d = (wr & hit_ctrl) ? wctrl : ctrl_q;
    assign ccr_d = ccr_wr ? pwdata[CW-1:0] : ccr_q;
    assign per_d = per_load ? new_per : per_q;
    assign pend_d = ccr_wr ? ~load_now : (pend_q & ~load_evt);
    assign cnt_d = clr ? CNT_RST :
        cnt_wr ? (pwdata[CW-1:0] & maxv) :
        (restart | enter_up) ? CNT_RST :
        step_use ? nxt : cnt_q;
    assign dir_d = (clr | restart) ? 1'b0 :
        step_use ? ndir : dir_q;
    assign div_d = clr ? 3'h0 :
        src_rise ? (tick ? 3'h0 : 3'(div_q + 3'h1)) : div_q;
    // a new event wins over a clear in the same cycle
    assign roll_d = (step_use & s_roll) |
        (roll_q & ~(stat_wr & pwdata[ST_ROLL]));
    assign match_d = (step_use & s_match) |
        (match_q & ~(stat_wr & pwdata[ST_MATCH]));

    // read mux; unused upper bits read zero
    wire [31:0] rdata = hit_ctrl ? 32'(ctrl_q) :
        hit_cnt ? 32'(cnt_q) :
        hit_ccr ? 32'(ccr_q) :
        hit_per ? 32'(per_q) :
        hit_stat ? 32'({dir_q, match_q, roll_q}) : 32'h0000_0000;

    // apb answer flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~mapped;
            if (acc & ~pready_q) begin
                prdata_q <= rdata;
            end
        end
    end

    // configuration and period state
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= plt_ctrl_s'(CTRL_RST);
            ccr_q <= CNT_RST;
            per_q <= CNT_RST;
            pend_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ccr_q <= ccr_d;
            per_q <= per_d;
            pend_q <= pend_d;
        end
    end

    // counter, direction, divider and flags
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= CNT_RST;
            dir_q <= 1'b0;
            div_q <= 3'h0;
            src_q <= 1'b0;
            roll_q <= 1'b0;
            match_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            div_q <= div_d;
            src_q <= src_lvl;
            roll_q <= roll_d;
            match_q <= match_d;
            irq_q <= roll_q & ctrl_q.irq_en;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

endmodule : plt_timer
`default_nettype wire

/* File: plt_timer_checker.sv */
// bus and status checker bound to the timer top
`timescale 1ns/1ps
`default_nettype none
module plt_timer_checker
    import plt_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic arst_n, // async reset, low active
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [AW-1:0] paddr, // byte address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic aux_clock, // source 0
    input wire logic sub_main_clock, // source 1
    input wire logic external_timer_clock, // source 2
    input wire logic alternate_external_clock, // source 3
    input wire logic irq // interrupt request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // address classes; anything off the word map must be refused
    wire logic unmapped = paddr[1:0] != 2'h0 || paddr > OFS_STAT;
    wire logic rd_done = pready && !pwrite;
    one_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    err_decode_a: assert property (pready |-> pslverr == unmapped)
        else $error("error response does not match address");
    err_rdata_a: assert property (rd_done && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    count_width_a: assert property (rd_done && paddr == OFS_COUNT
        |-> prdata[31:16] == 16'h0)
        else $error("count wider than sixteen bits");
    clear_reads_a: assert property (rd_done && paddr == OFS_CTRL
        |-> prdata[31:11] == 21'h0)
        else $error("clear bit or upper control bits read set");
    stat_width_a: assert property (rd_done && paddr == OFS_STAT
        |-> prdata[31:3] == 29'h0)
        else $error("status upper bits read set");
endmodule : plt_timer_checker
bind plt_timer plt_timer_checker chk (.mclk(mclk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_clock(aux_clock), .sub_main_clock(sub_main_clock),
    .external_timer_clock(external_timer_clock),
    .alternate_external_clock(alternate_external_clock), .irq(irq));
`default_nettype wire

/* File: plt_timer_tb.sv */
// self-checking bench for timer registers and counting modes
`timescale 1ns/1ps
`default_nettype none
module plt_timer_tb;
    import plt_pkg::*;
    typedef struct packed {
        logic rd;
        logic err;
        logic [31:0] d;
    } plt_note_s;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, seed = 32'd51, r;
    logic pready, pslverr, irq;
    logic [3:0] srcs = 4'h0;
    logic [1:0] sel = 2'h0;
    logic [15:0] mx [4] = '{MAX_8, MAX_10, MAX_12, MAX_16};
    int failures = 0, checks_done = 0, cycles = 0;
    plt_note_s notes[$];
    plt_note_s note;
    always #2.5 mclk = ~mclk;
    plt_timer uut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .aux_clock(srcs[0]), .sub_main_clock(srcs[1]),
        .external_timer_clock(srcs[2]),
        .alternate_external_clock(srcs[3]), .irq(irq));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        $display("counts: %0d checks, %0d mismatches", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // one bus transfer; its expected answer is queued first
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
        logic [31:0] e, logic err);
        notes.push_back('{rd: !w, err: err, d: e});
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(logic [7:0] a, logic [31:0] d);
        xfer(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] e);
        xfer(1'b0, a, 32'h0, e, 1'b0);
    endtask : rd
    task automatic ctl(logic [1:0] m, s, d, l, logic c);
        plt_ctrl_s f;
        f = '{lls: LLS_IMM, irq_en: 1'b1, len: l, div: d, src: s, mode: m};
        sel = s;
        wr(OFS_CTRL, {20'h0, c, f});
    endtask : ctl
    // rises on the selected source; others get noise that must not count
    task automatic pulse(int n);
        repeat (n) begin
            @(posedge mclk);
            srcs <= 4'(rnd()) & ~(4'h1 << sel);
            @(posedge mclk);
            srcs <= 4'(rnd()) | (4'h1 << sel);
        end
        repeat (3) @(posedge mclk);
    endtask : pulse
    // oldest note against each completed transfer
    always @(posedge mclk) begin
        if (pready === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            chk("pslverr", {31'h0, note.err}, {31'h0, pslverr});
            if (note.rd)
                chk("prdata", note.d, prdata);
        end
    end
    // hang guard, far above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_STAT, 32'h0);
        wr(OFS_PERIOD, 32'h7);
        rd(OFS_PERIOD, 32'h0);
        xfer(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            // software stops the timer before each reconfiguration
            ctl(MODE_STOP, SRC_AUX, 2'h0, 2'(i), 1'b0);
            wr(OFS_COUNT, r);
            rd(OFS_COUNT, r & {16'h0, mx[i]});
        end
        $display("test lengths done");
        wr(OFS_CCR0, 32'h3);
        rd(OFS_PERIOD, 32'h3);
        wr(OFS_COUNT, 32'h0);
        ctl(MODE_UP, SRC_AUX, 2'h0, 2'h3, 1'b0);
        pulse(3);
        rd(OFS_COUNT, 32'h3);
        rd(OFS_STAT, 32'h2);
        pulse(1);
        rd(OFS_COUNT, 32'h0);
        rd(OFS_STAT, 32'h3);
        chk("irq", 32'h1, {31'h0, irq});
        wr(OFS_STAT, 32'h3);
        wr(OFS_COUNT, 32'h3);
        rd(OFS_STAT, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test up mode done");
        for (int s = 0; s < 4; s++) begin
            ctl(MODE_CONT, 2'(s), 2'(s), 2'h3, 1'b1);
            pulse(8);
            rd(OFS_COUNT, 32'h8 >> s);
        end
        ctl(MODE_STOP, SRC_AUX, 2'h0, LEN_8, 1'b0);
        wr(OFS_STAT, 32'h3);
        wr(OFS_COUNT, 32'h1FE);
        ctl(MODE_CONT, SRC_AUX, 2'h0, LEN_8, 1'b0);
        pulse(2);
        rd(OFS_COUNT, 32'h0);
        rd(OFS_STAT, 32'h1);
        $display("test sources and continuous done");
        ctl(MODE_UPDN, SRC_AUX, 2'h0, 2'h3, 1'b1);
        wr(OFS_STAT, 32'h3);
        pulse(4);
        rd(OFS_COUNT, 32'h2);
        rd(OFS_STAT, 32'h6);
        ctl(MODE_STOP, SRC_AUX, 2'h0, 2'h3, 1'b0);
        pulse(2);
        rd(OFS_COUNT, 32'h2);
        ctl(MODE_UPDN, SRC_AUX, 2'h0, 2'h3, 1'b0);
        pulse(1);
        rd(OFS_COUNT, 32'h1);
        pulse(1);
        ctl(MODE_UPDN, SRC_AUX, 2'h0, 2'h3, 1'b1);
        rd(OFS_STAT, 32'h3);
        $display("test up/down done");
        wr(OFS_CCR0, 32'h5);
        ctl(MODE_UP, SRC_AUX, 2'h0, 2'h3, 1'b0);
        wr(OFS_COUNT, 32'h4);
        wr(OFS_CCR0, 32'h0);
        pulse(2);
        rd(OFS_COUNT, 32'h4);
        wr(OFS_CCR0, 32'h5);
        pulse(1);
        rd(OFS_COUNT, 32'h1);
        ctl(MODE_STOP, SRC_AUX, 2'h0, 2'h3, 1'b0);
        wr(OFS_COUNT, 32'h9);
        ctl(MODE_UP, SRC_AUX, 2'h0, 2'h3, 1'b0);
        rd(OFS_COUNT, 32'h0);
        $display("test period load done");
        wrap_up();
    end
endmodule : plt_timer_tb
`default_nettype wire
